//--- ipd_map.vh
`ifndef IPD_MAP_VH
`define IPD_MAP_VH
// register byte addresses: four times the word index
`define IPD_SEL_ADDR        32'h0003FF00
`define IPD_POL0_ADDR       32'h0003FF04
`define IPD_POL1_ADDR       32'h0003FF08
`define IPD_LVL0_ADDR       32'h0003FF0C
`define IPD_LVL1_ADDR       32'h0003FF10
`define IPD_STAT_ADDR       32'h0003FF20
`define IPD_MASK_ADDR       32'h0003FF30
// word indices (printed offsets are not all multiples of four)
`define IPD_SEL_IDX         16'hFFC0
`define IPD_POL0_IDX        16'hFFC1
`define IPD_POL1_IDX        16'hFFC2
`define IPD_LVL0_IDX        16'hFFC3
`define IPD_LVL1_IDX        16'hFFC4
`define IPD_STAT_IDX        16'hFFC8
`define IPD_MASK_IDX        16'hFFCC
// field positions
`define IPD_STAT_G0_BIT     0
`define IPD_STAT_G1_LSB     1
`define IPD_STAT_G1_MSB     4
// reset values
`define IPD_SEL_RST         8'h00
`define IPD_POL0_RST        8'hFF
`define IPD_POL1_RST        4'hF
`define IPD_STAT_RST        5'h00
`define IPD_MASK_RST        5'h00
`endif

//--- ipd_sync.v
`timescale 1ns/1ns
module ipd_sync #(
    parameter W = 8
) (
    input  wire         sys_clk,
    input  wire         rst_n,
    input  wire [W-1:0] pinIn,
    output reg  [W-1:0] levelQ
);
    // three stages; first stage is read only by the second
    reg [W-1:0] s1_q;
    reg [W-1:0] s2_q;
    reg [W-1:0] s3_q;
    integer     i;
    // a bit changes only when stages two and three agree
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            s1_q   <= {W{1'b0}};
            s2_q   <= {W{1'b0}};
            s3_q   <= {W{1'b0}};
            levelQ <= {W{1'b0}};
        end else begin
            s1_q <= pinIn;
            s2_q <= s1_q;
            s3_q <= s2_q;
            for (i = 0; i < W; i = i + 1) begin
                if (s2_q[i] == s3_q[i]) begin
                    levelQ[i] <= s3_q[i];
                end
            end
        end
    end
endmodule

//--- ipd_edge.v
`timescale 1ns/1ns
module ipd_edge #(
    parameter W = 8
) (
    input  wire         sys_clk,
    input  wire         rst_n,
    input  wire [W-1:0] level,
    input  wire [W-1:0] fallSel,
    output wire [W-1:0] edgeHit
);
    reg [W-1:0] prev_q;
    reg         armed_q;
    // remember last level; no edges before first valid sample
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            prev_q  <= {W{1'b0}};
            armed_q <= 1'b0;
        end else begin
            prev_q  <= level;
            armed_q <= 1'b1;
        end
    end
    // polarity one picks falling, zero rising
    assign edgeHit = {W{armed_q}} & ((fallSel & prev_q & ~level) | (~fallSel & ~prev_q & level));
endmodule

//--- ipd_input_port.v
// Chosen here: the AHB-Lite register port.
`timescale 1ns/1ns
`include "ipd_map.vh"
module ipd_input_port (
    input  wire        sys_clk,
    input  wire        rst_n,
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output reg  [31:0] hrdata,
    output reg         hreadyout,
    output reg         hresp,
    input  wire [7:0]  firstGroupPins,
    input  wire [3:0]  secondGroupPins,
    output reg         irq
);
    //--------------------------------------------------------------
    // register selects
    //--------------------------------------------------------------
    // internal codes for the decoded word; zero means nothing mapped
    // the level words decode like the rest but have no write path
    localparam [2:0] SEL_NONE   = 3'h0;
    localparam [2:0] SEL_IRQSEL = 3'h1;
    localparam [2:0] SEL_POL0   = 3'h2;
    localparam [2:0] SEL_POL1   = 3'h3;
    localparam [2:0] SEL_LVL0   = 3'h4;
    localparam [2:0] SEL_LVL1   = 3'h5;
    localparam [2:0] SEL_STAT   = 3'h6;
    localparam [2:0] SEL_MASK   = 3'h7;

    //--------------------------------------------------------------
    // word index decode
    //--------------------------------------------------------------
    // unmapped words decode to SEL_NONE and read as zero
    function [2:0] decodeIdx;
        input [31:0] addr;
        begin
            case (addr[31:2])
                {14'h0000, `IPD_SEL_IDX}:  decodeIdx = SEL_IRQSEL;
                {14'h0000, `IPD_POL0_IDX}: decodeIdx = SEL_POL0;
                {14'h0000, `IPD_POL1_IDX}: decodeIdx = SEL_POL1;
                {14'h0000, `IPD_LVL0_IDX}: decodeIdx = SEL_LVL0;
                {14'h0000, `IPD_LVL1_IDX}: decodeIdx = SEL_LVL1;
                {14'h0000, `IPD_STAT_IDX}: decodeIdx = SEL_STAT;
                {14'h0000, `IPD_MASK_IDX}: decodeIdx = SEL_MASK;
                default:                   decodeIdx = SEL_NONE;
            endcase
        end
    endfunction

    // a transfer counts only with the bus ready and a NONSEQ or SEQ
    function busTake;
        input       selIn;
        input       readyIn;
        input [1:0] transIn;
        begin
            busTake = selIn & readyIn & transIn[1];
        end
    endfunction

    // true in the data phase of a write to the given word
    function wrHit;
        input       pend;
        input [2:0] idx;
        input [2:0] want;
        begin
            wrHit = pend & (idx == want);
        end
    endfunction

    // set wins over a clear in the same cycle, so no edge is lost
    function [4:0] flagNext;
        input [4:0] curIn;
        input [4:0] clrIn;
        input [4:0] setIn;
        begin
            flagNext = (curIn & ~clrIn) | setIn;
        end
    endfunction

    //--------------------------------------------------------------
    // internal signals
    //--------------------------------------------------------------
    // synchronised levels and edge strobes of the two pin groups
    wire [7:0]  lvl0;
    wire [3:0]  lvl1;
    wire [7:0]  hit0;
    wire [3:0]  hit1;
    // address phase decode
    wire        busTaken;
    wire        rdTaken;
    wire        wrTaken;
    wire [2:0]  addrSel;
    // control and flag registers with their next values
    reg  [7:0]  irqSel_q;
    reg  [7:0]  irqSel_d;
    reg  [7:0]  pol0_q;
    reg  [7:0]  pol0_d;
    reg  [3:0]  pol1_q;
    reg  [3:0]  pol1_d;
    reg  [4:0]  stat_q;
    reg  [4:0]  stat_d;
    reg  [4:0]  mask_q;
    reg  [4:0]  mask_d;
    // write pipeline: the data phase follows its address phase
    reg         wrPend_q;
    reg         wrPend_d;
    reg  [2:0]  wrIdx_q;
    reg  [2:0]  wrIdx_d;
    // output next values and flag terms
    reg  [31:0] hrdata_d;
    reg         irq_d;
    reg  [4:0]  setBits;
    reg  [4:0]  clrBits;
    reg  [31:0] rdMux;

    //--------------------------------------------------------------
    // pin synchronisers and edge detectors
    //--------------------------------------------------------------
    ipd_sync #(.W(8)) uSync0 (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .pinIn   (firstGroupPins),
        .levelQ  (lvl0)
    );
    ipd_sync #(.W(4)) uSync1 (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .pinIn   (secondGroupPins),
        .levelQ  (lvl1)
    );
    ipd_edge #(.W(8)) uEdge0 (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .level   (lvl0),
        .fallSel (pol0_q),
        .edgeHit (hit0)
    );
    ipd_edge #(.W(4)) uEdge1 (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .level   (lvl1),
        .fallSel (pol1_q),
        .edgeHit (hit1)
    );

    //--------------------------------------------------------------
    // flag set and clear terms
    //--------------------------------------------------------------
    // the first group folds into one flag, the second keeps one per pin
    // edges set flags whatever the mask holds
    always @* begin
        setBits = {hit1, |(hit0 & irqSel_q)};
    end

    // a clear acts only in the data phase of a status write
    always @* begin
        clrBits = 5'h00;
        if (wrHit(wrPend_q, wrIdx_q, SEL_STAT)) begin
            clrBits = hwdata[4:0];
        end
    end

    // irq takes the next flag value so it lines up with a status read
    // a pin edge in the clear cycle still leaves its flag set
    always @* begin
        stat_d = flagNext(stat_q, clrBits, setBits);
        irq_d  = |(stat_d & mask_q);
    end

    //--------------------------------------------------------------
    // address phase decode
    //--------------------------------------------------------------
    // one decode feeds both the read mux and the write pipeline
    // hready is our own hreadyout fed back, as the only slave
    assign addrSel  = decodeIdx(haddr);
    assign busTaken = busTake(hsel, hready, htrans);
    assign rdTaken  = busTaken & ~hwrite;
    assign wrTaken  = busTaken & hwrite;

    // read mux; level bits come live from the synchronised pins
    // upper bits stay zero so narrow registers never show junk
    always @* begin
        case (addrSel)
            SEL_IRQSEL: rdMux = {24'h000000, irqSel_q};
            SEL_POL0:   rdMux = {24'h000000, pol0_q};
            SEL_POL1:   rdMux = {28'h0000000, pol1_q};
            SEL_LVL0:   rdMux = {24'h000000, lvl0};
            SEL_LVL1:   rdMux = {28'h0000000, lvl1};
            SEL_STAT:   rdMux = {27'h0000000, stat_q};
            SEL_MASK:   rdMux = {27'h0000000, mask_q};
            default:    rdMux = 32'h00000000;
        endcase
    end

    // read data is captured at the address edge and then held
    always @* begin
        hrdata_d = hrdata;
        if (rdTaken) begin
            hrdata_d = rdMux;
        end
    end

    // the write data only stands one cycle after its address
    // level selects pass here but no next-value block takes them
    always @* begin
        wrPend_d = wrTaken;
        wrIdx_d  = addrSel;
    end

    //--------------------------------------------------------------
    // control register next values
    //--------------------------------------------------------------
    // each register holds unless the data phase of its own write
    // a zero select bit keeps its pin out of the shared flag
    always @* begin
        irqSel_d = irqSel_q;
        if (wrHit(wrPend_q, wrIdx_q, SEL_IRQSEL)) begin
            irqSel_d = hwdata[7:0];
        end
    end

    // a one picks the falling edge for that pin
    always @* begin
        pol0_d = pol0_q;
        if (wrHit(wrPend_q, wrIdx_q, SEL_POL0)) begin
            pol0_d = hwdata[7:0];
        end
    end

    // only four second-group pins; upper data bits are dropped
    always @* begin
        pol1_d = pol1_q;
        if (wrHit(wrPend_q, wrIdx_q, SEL_POL1)) begin
            pol1_d = hwdata[3:0];
        end
    end

    // mask only gates the output, never the flags
    always @* begin
        mask_d = mask_q;
        if (wrHit(wrPend_q, wrIdx_q, SEL_MASK)) begin
            mask_d = hwdata[4:0];
        end
    end

    //--------------------------------------------------------------
    // registers
    //--------------------------------------------------------------
    // every register loads each clock; holding lives in the next values
    // bus side outputs; no wait states and no errors, both held in flops
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            hrdata    <= 32'h00000000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            wrPend_q  <= 1'b0;
            wrIdx_q   <= SEL_NONE;
        end else begin
            hrdata    <= hrdata_d;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            wrPend_q  <= wrPend_d;
            wrIdx_q   <= wrIdx_d;
        end
    end

    // control registers; polarity resets to the falling edge
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            irqSel_q <= `IPD_SEL_RST;
            pol0_q   <= `IPD_POL0_RST;
            pol1_q   <= `IPD_POL1_RST;
            mask_q   <= `IPD_MASK_RST;
        end else begin
            irqSel_q <= irqSel_d;
            pol0_q   <= pol0_d;
            pol1_q   <= pol1_d;
            mask_q   <= mask_d;
        end
    end

    // flags and interrupt level; irq is a flop so it never glitches
    // a mask change reaches irq one cycle after the write lands
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            stat_q <= `IPD_STAT_RST;
            irq    <= 1'b0;
        end else begin
            stat_q <= stat_d;
            irq    <= irq_d;
        end
    end
endmodule

//--- ipd_input_port_monitor.sv
`timescale 1ns/1ns
`include "ipd_map.vh"
module ipd_input_port_monitor (
    input wire        sys_clk,
    input wire        rst_n,
    input wire        hsel,
    input wire [31:0] haddr,
    input wire [1:0]  htrans,
    input wire        hwrite,
    input wire [2:0]  hsize,
    input wire [31:0] hwdata,
    input wire        hready,
    input wire [31:0] hrdata,
    input wire        hreadyout,
    input wire        hresp,
    input wire [7:0]  firstGroupPins,
    input wire [3:0]  secondGroupPins,
    input wire        irq
);
    // ----
    // bus decode and checks
    // ----
    // pins must sit still 8 samples so the synchroniser delay is covered
    wire take = hsel & hready & htrans[1];
    wire rd   = take & !hwrite;
    wire wr   = take & hwrite;
    wire inL0 = haddr == {14'h0, `IPD_LVL0_IDX, 2'h0};
    wire inL1 = haddr == {14'h0, `IPD_LVL1_IDX, 2'h0};
    wire inMk = haddr == {14'h0, `IPD_MASK_IDX, 2'h0};
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    a_resp_okay: assert property (hresp == 1'b0) else $error("hresp not okay");
    a_ready_high: assert property (hreadyout) else $error("wait state seen");
    a_first_level: assert property ($stable(firstGroupPins)[*8] ##0 (rd && inL0)
        |=> hrdata == {24'h0, $past(firstGroupPins)}) else $error("first group level wrong");
    a_second_level: assert property ($stable(secondGroupPins)[*8] ##0 (rd && inL1)
        |=> hrdata == {28'h0, $past(secondGroupPins)}) else $error("second group level wrong");
    a_unmapped_zero: assert property (rd && haddr == 32'h0 |=> hrdata == 32'h0) else $error("unmapped read");
    a_rdata_holds: assert property ($past(rst_n) && !$past(rd) |-> $stable(hrdata)) else $error("hrdata moved");
    a_mask_off: assert property ($past(wr && inMk) && hwdata[4:0] == 5'h00 |-> ##2 !irq) else $error("irq unmasked");
    a_irq_quiet: assert property ((!wr && $stable(firstGroupPins) && $stable(secondGroupPins))[*8]
        |-> !$rose(irq)) else $error("irq without cause");
endmodule
bind ipd_input_port ipd_input_port_monitor u_mon (.*);

//--- ipd_key_model.sv
`timescale 1ns/1ns
// ----
// key switch bank
// ----
module ipd_key_model (
    input  wire       sys_clk,
    input  wire [7:0] wantFirst,
    input  wire [3:0] wantSecond,
    output reg  [7:0] firstGroupPins,
    output reg  [3:0] secondGroupPins
);
    // contacts move 1 ns after each rising edge of the sampling clock
    always @(posedge sys_clk) begin
        firstGroupPins  <= #1 wantFirst;
        secondGroupPins <= #1 wantSecond;
    end
endmodule

//--- test_ipd_input_port.sv
`timescale 1ns/1ns
`include "ipd_map.vh"
module test_ipd_input_port;
    // ----
    // stimulus and scoreboard
    // ----
    reg         sys_clk    = 1'b0;
    reg         rst_n      = 1'b0;
    reg         hsel       = 1'b0;
    reg  [31:0] haddr      = 32'h0;
    reg  [1:0]  htrans     = 2'h0;
    reg         hwrite     = 1'b0;
    reg  [31:0] hwdata     = 32'h0;
    reg  [7:0]  wantFirst  = 8'h0;
    reg  [3:0]  wantSecond = 4'h0;
    reg  [31:0] rdv;
    reg  [31:0] rnd;
    wire [31:0] hrdata;
    wire        hreadyout;
    wire        irq;
    wire [7:0]  firstPins;
    wire [3:0]  secondPins;
    integer     err_count   = 0;
    integer     check_count = 0;
    integer     cycles      = 0;
    integer     seed        = 32'h5F8BEA75;
    integer     i;
    ipd_input_port u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(), .firstGroupPins(firstPins), .secondGroupPins(secondPins), .irq(irq));
    ipd_key_model u_keys (.sys_clk(sys_clk), .wantFirst(wantFirst), .wantSecond(wantSecond),
        .firstGroupPins(firstPins), .secondGroupPins(secondPins));
    // clock and hang guard
    initial begin
        forever #2 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_count = err_count + 1;
            close_out;
        end
    end
    task close_out;
        if (err_count == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task chk(input [31:0] seen, input [31:0] exp);
        check_count = check_count + 1;
        if (seen !== exp) begin
            err_count = err_count + 1;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one single transfer; the master waits for hready, never a fixed count
    task xfer(input w, input [15:0] idx, input [31:0] d);
        @(posedge sys_clk);
        hsel   <= 1'b1;
        haddr  <= {14'h0, idx, 2'h0};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        rdv = hrdata;
    endtask
    task rd(input [15:0] idx, input [31:0] exp);
        xfer(1'b0, idx, 32'h0);
        chk(rdv, exp);
    endtask
    function [31:0] word(input [7:0] v);
        word = {24'h0, v};
    endfunction
    // main sequence: reset values, live levels, edges and flags
    initial begin
        repeat (6) @(posedge sys_clk);
        rst_n <= 1'b1;
        rd(`IPD_POL0_IDX, word(`IPD_POL0_RST));
        rd(`IPD_POL1_IDX, word(`IPD_POL1_RST));
        rd(`IPD_SEL_IDX, 32'h0);
        rd(`IPD_STAT_IDX, 32'h0);
        for (i = 0; i < 12; i = i + 1) begin
            rnd = (i < 2) ? {32{i[0]}} : $random(seed);
            wantFirst  <= rnd[7:0];
            wantSecond <= rnd[11:8];
            xfer(1'b1, `IPD_LVL0_IDX, ~rnd);
            xfer(1'b1, `IPD_LVL1_IDX, ~rnd);
            repeat (8) @(posedge sys_clk);
            rd(`IPD_LVL0_IDX, word(wantFirst));
            rd(`IPD_LVL1_IDX, word({4'h0, wantSecond}));
        end
        xfer(1'b1, 16'h0, 32'hFFFFFFFF);
        rd(16'h0, 32'h0);
        wantFirst  <= 8'h00;
        wantSecond <= 4'h0;
        xfer(1'b1, `IPD_SEL_IDX, 32'h3);
        xfer(1'b1, `IPD_POL0_IDX, 32'hFE);
        repeat (8) @(posedge sys_clk);
        xfer(1'b1, `IPD_STAT_IDX, 32'h1F);
        rd(`IPD_STAT_IDX, 32'h0);
        // deselected pin toggles, then a rising edge on a falling-edge pin
        wantFirst <= 8'h04;
        repeat (8) @(posedge sys_clk);
        wantFirst <= 8'h02;
        repeat (8) @(posedge sys_clk);
        rd(`IPD_STAT_IDX, 32'h0);
        wantFirst <= 8'h03;
        repeat (8) @(posedge sys_clk);
        rd(`IPD_STAT_IDX, 32'h1);
        chk({31'h0, irq}, 32'h0);
        xfer(1'b1, `IPD_STAT_IDX, 32'h0);
        rd(`IPD_STAT_IDX, 32'h1);
        xfer(1'b1, `IPD_MASK_IDX, 32'h1);
        repeat (3) @(posedge sys_clk);
        chk({31'h0, irq}, 32'h1);
        xfer(1'b1, `IPD_STAT_IDX, 32'h1);
        repeat (3) @(posedge sys_clk);
        chk({31'h0, irq}, 32'h0);
        wantSecond <= 4'h2;
        repeat (8) @(posedge sys_clk);
        wantSecond <= 4'h0;
        repeat (8) @(posedge sys_clk);
        rd(`IPD_STAT_IDX, 32'h4);
        // unmask the second-group flag, then mask it off again
        xfer(1'b1, `IPD_MASK_IDX, 32'h4);
        repeat (3) @(posedge sys_clk);
        chk({31'h0, irq}, 32'h1);
        xfer(1'b1, `IPD_MASK_IDX, 32'h0);
        repeat (4) @(posedge sys_clk);
        chk({31'h0, irq}, 32'h0);
        close_out;
    end
endmodule
